// *** verilog/ptb_defines.vh ***
`ifndef PTB_DEFINES_VH
`define PTB_DEFINES_VH

// Counter and value width
`define PTB_CNT_W 16
// Reset values
`define PTB_PERIOD_RST 16'hffff
`define PTB_CMP_RST 16'h0000
`define PTB_PHASE_RST 16'h0000
`define PTB_ZERO 16'h0000
// sync_shadow_load_select encodings
`define PTB_LD_ZERO 1'b0
`define PTB_LD_ZERO_SYNC 1'b1

`endif

// *** verilog/ptb_timebase.v ***
// Contract
// - With phase loading enabled, each sync pulse copies phase_value into the counter.
// - Shadow period moves to active period when the counter reaches zero.
// - Phase above period lets the counter climb past period until full-width wrap.
// - Sync-load bit set makes sync a load point for period and compares.
// - With shadowing on, writes hit only the shadow, except in a load cycle; active waits for load.
`timescale 1ns/1ns
`default_nettype none
`include "ptb_defines.vh"

module ptb_timebase #(
  parameter W = `PTB_CNT_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Sync from the sync source, pin-level pulse
  input wire sync_input_pulse,
  // Configuration
  input wire phase_load_en,
  input wire shadow_en,
  input wire sync_shadow_load_select,
  input wire [W-1:0] phase_value,
  // Software writes
  input wire period_wr,
  input wire [W-1:0] period_wdata,
  input wire cmpa_wr,
  input wire [W-1:0] cmpa_wdata,
  input wire cmpb_wr,
  input wire [W-1:0] cmpb_wdata,
  // State
  output wire [W-1:0] timebase_counter,
  output wire [W-1:0] period_active,
  output wire [W-1:0] cmpa_active,
  output wire [W-1:0] cmpb_active,
  output wire [W-1:0] period_shadow,
  output wire shadow_load_pulse,
  output wire sync_seen,
  output wire ctr_zero
);

  reg sync_m_ff;
  reg sync_s_ff;
  reg sync_d_ff;
  reg [W-1:0] timebase_cnt_ff;
  reg [W-1:0] nxt_timebase_cnt;
  reg shadow_load_pulse_ff;
  reg sync_seen_ff;
  reg ctr_zero_ff;
  wire sync_evt;
  wire zero_evt;
  wire load_evt;
  wire [W-1:0] nxt_cnt;

  // Two-flop synchroniser; the edge detector only sees the second stage
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sync_m_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end else begin
      sync_m_ff <= sync_input_pulse;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  assign sync_evt = sync_s_ff & ~sync_d_ff;

  // Up count, reset to zero at period; a counter above period just runs to wrap
  assign nxt_cnt = (timebase_counter == period_active) ? `PTB_ZERO :
                   timebase_counter + {{(W-1){1'b0}}, 1'b1};

  assign zero_evt = (timebase_counter == `PTB_ZERO);
  // Zero loads, and sync loads when sync_shadow_load_select is set; each later event loads again
  assign load_evt = zero_evt |
    (sync_evt & (sync_shadow_load_select == `PTB_LD_ZERO_SYNC));

  // Phase load takes priority over counting, even in the zero cycle
  always @* begin
    nxt_timebase_cnt = nxt_cnt;
    if (sync_evt && phase_load_en) begin
      nxt_timebase_cnt = phase_value;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      timebase_cnt_ff <= `PTB_ZERO;
    end else begin
      timebase_cnt_ff <= nxt_timebase_cnt;
    end
  end

  assign timebase_counter = timebase_cnt_ff;

  // One shadow/active pair per register; a shared load_evt keeps them in step
  ptb_shadow_reg #(
    .W(W),
    .RST_VAL(`PTB_PERIOD_RST)
  ) period_reg_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .shadow_en(shadow_en),
    .load_evt(load_evt),
    .wr(period_wr),
    .wdata(period_wdata),
    .shadow_val(period_shadow),
    .active_val(period_active)
  );

  ptb_shadow_reg #(
    .W(W),
    .RST_VAL(`PTB_CMP_RST)
  ) cmpa_reg_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .shadow_en(shadow_en),
    .load_evt(load_evt),
    .wr(cmpa_wr),
    .wdata(cmpa_wdata),
    .shadow_val(),
    .active_val(cmpa_active)
  );

  ptb_shadow_reg #(
    .W(W),
    .RST_VAL(`PTB_CMP_RST)
  ) cmpb_reg_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .shadow_en(shadow_en),
    .load_evt(load_evt),
    .wr(cmpb_wr),
    .wdata(cmpb_wdata),
    .shadow_val(),
    .active_val(cmpb_active)
  );

  // Marks the cycle after a shadow transfer, for software to resync its writes
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      shadow_load_pulse_ff <= 1'b0;
    end else begin
      shadow_load_pulse_ff <= shadow_en & load_evt;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sync_seen_ff <= 1'b0;
      ctr_zero_ff <= 1'b0;
    end else begin
      sync_seen_ff <= sync_evt;
      ctr_zero_ff <= zero_evt;
    end
  end

  assign shadow_load_pulse = shadow_load_pulse_ff;
  assign sync_seen = sync_seen_ff;
  assign ctr_zero = ctr_zero_ff;

endmodule

// One shadowed register: software writes the shadow, hardware moves it to active
module ptb_shadow_reg #(
  parameter W = `PTB_CNT_W,
  parameter [W-1:0] RST_VAL = `PTB_PERIOD_RST
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Mode and load event
  input wire shadow_en,
  input wire load_evt,
  // Software write
  input wire wr,
  input wire [W-1:0] wdata,
  // Register contents
  output wire [W-1:0] shadow_val,
  output wire [W-1:0] active_val
);

  reg [W-1:0] shadow_ff;
  reg [W-1:0] active_ff;
  reg [W-1:0] nxt_shadow;
  reg [W-1:0] nxt_active;

  // Shadow always follows the last write, in either mode
  always @* begin
    nxt_shadow = shadow_ff;
    if (wr) begin
      nxt_shadow = wdata;
    end
  end

  // Direct mode writes through; shadow mode moves only at a load event.
  // A write in the load cycle goes straight to active so it is not lost.
  always @* begin
    nxt_active = active_ff;
    if (!shadow_en) begin
      if (wr) begin
        nxt_active = wdata;
      end
    end else if (load_evt) begin
      nxt_active = wr ? wdata : shadow_ff;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      shadow_ff <= RST_VAL;
      active_ff <= RST_VAL;
    end else begin
      shadow_ff <= nxt_shadow;
      active_ff <= nxt_active;
    end
  end

  assign shadow_val = shadow_ff;
  assign active_val = active_ff;

endmodule
`default_nettype wire

// *** dv/ptb_sync_src.sv ***
`timescale 1ns/1ns
`default_nettype none
module ptb_sync_src (input wire clk_sys, input wire fire, output logic sync_input_pulse);
  // Registered so the pulse never races the bench's falling-edge drive
  always @(posedge clk_sys) sync_input_pulse <= fire;
endmodule
`default_nettype wire

// *** dv/ptb_timebase_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module ptb_monitor (
  input wire clk_sys, rst_b, shadow_en, sync_shadow_load_select, phase_load_en,
  input wire sync_seen, shadow_load_pulse, period_wr,
  input wire [15:0] period_wdata,
  input wire [15:0] phase_value, timebase_counter, period_active, period_shadow, cmpa_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_phase_ld: assert property (sync_seen && phase_load_en
    |-> timebase_counter == $past(phase_value)) else $error("phase missed");
  a_zero_ld: assert property ($past(timebase_counter) == 0 && $past(shadow_en)
    |-> period_active == ($past(period_wr) ? $past(period_wdata) : $past(period_shadow)))
    else $error("zero load missed");
  a_wrap_up: assert property (timebase_counter > period_active |=> sync_seen
    || timebase_counter == $past(timebase_counter) + 16'h0001) else $error("no climb");
  a_sync_ld: assert property (sync_seen && $past(sync_shadow_load_select)
    && $past(shadow_en) |-> period_active == ($past(period_wr) ? $past(period_wdata)
    : $past(period_shadow))) else $error("sync load");
  a_hold_act: assert property ($changed(period_active) && $past(shadow_en)
    |-> shadow_load_pulse) else $error("period moved");
  a_pair_ld: assert property ($changed(cmpa_active) && $past(shadow_en)
    |-> shadow_load_pulse) else $error("compare moved");
endmodule
bind ptb_timebase ptb_monitor mon_u(.*);
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 0, rst_b = 0, fire = 0, period_wr = 0, cmpa_wr = 0, cmpb_wr = 0, ctr_zero;
  logic phase_load_en = 1, shadow_en = 1, sync_shadow_load_select = 1, sync_input_pulse;
  logic [15:0] phase_value = 0, period_wdata = 0, cmpa_wdata = 0, cmpb_wdata = 0, cmpb_active;
  logic [15:0] timebase_counter, period_active, cmpa_active, period_shadow;
  logic shadow_load_pulse, sync_seen;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  ptb_timebase dut_u(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sync_input_pulse(sync_input_pulse),
    .phase_load_en(phase_load_en),
    .shadow_en(shadow_en),
    .sync_shadow_load_select(sync_shadow_load_select),
    .phase_value(phase_value),
    .period_wr(period_wr),
    .period_wdata(period_wdata),
    .cmpa_wr(cmpa_wr),
    .cmpa_wdata(cmpa_wdata),
    .cmpb_wr(cmpb_wr),
    .cmpb_wdata(cmpb_wdata),
    .timebase_counter(timebase_counter),
    .period_active(period_active),
    .cmpa_active(cmpa_active),
    .cmpb_active(cmpb_active),
    .period_shadow(period_shadow),
    .shadow_load_pulse(shadow_load_pulse),
    .sync_seen(sync_seen),
    .ctr_zero(ctr_zero)
  );
  ptb_sync_src src_u(.clk_sys(clk_sys), .fire(fire), .sync_input_pulse(sync_input_pulse));
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 300) begin
    n_fail++;
    tally_and_finish;
  end
  task chk(input [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t %h %h", $time, g, e);
    end
  endtask
  task wr(input [15:0] p, c);
    {period_wdata, cmpa_wdata, cmpb_wdata} = {p, c, c + 16'h0001};
    {period_wr, cmpa_wr, cmpb_wr} = 3'b111;
    @(negedge clk_sys);
    {period_wr, cmpa_wr, cmpb_wr} = 3'b000;
  endtask
  task pulse;
    fire = 1;
    @(negedge clk_sys);
    fire = 0;
    repeat (8) if (!sync_seen) @(negedge clk_sys);
  endtask
  task t_sync;
    phase_value = 16'h0014 / 2 * (2 - 1);
    wr(16'h0014, 16'h0007);
    chk(period_active, 16'hffff);
    chk(period_shadow, 16'h0014);
    chk(cmpb_active, 16'h0000);
    pulse;
    chk({15'h0000, sync_seen}, 16'h0001);
    chk(timebase_counter, phase_value);
    chk(period_active, 16'h0014);
    chk({15'h0000, shadow_load_pulse}, 16'h0001);
    chk(cmpa_active, 16'h0007);
    chk(cmpb_active, 16'h0008);
    $display("sync load done");
  endtask
  task t_wrap;
    {sync_shadow_load_select, phase_value} = {1'b0, 16'hfff0};
    wr(16'h000c, 16'h0004);
    pulse;
    chk(period_active, 16'h0014);
    chk({15'h0000, shadow_load_pulse}, 16'h0000);
    repeat (15) @(negedge clk_sys);
    chk(timebase_counter, 16'hffff);
    repeat (2) @(negedge clk_sys);
    chk(period_active, 16'h000c);
    chk({15'h0000, ctr_zero}, 16'h0001);
    chk({15'h0000, shadow_load_pulse}, 16'h0001);
    chk(cmpa_active, 16'h0004);
    chk(cmpb_active, 16'h0005);
    $display("wrap load done");
  endtask
  task t_direct;
    shadow_en = 0;
    wr(16'h0030, 16'h0009);
    chk(period_active, 16'h0030);
    chk(cmpb_active, 16'h000a);
    shadow_en = 1;
    $display("direct write done");
  endtask
  task tally_and_finish;
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_b = 1;
    // Skip the zero-count cycle after reset so the first write lands in shadow only
    repeat (2) @(negedge clk_sys);
    t_sync;
    t_wrap;
    t_direct;
    tally_and_finish;
  end
endmodule
`default_nettype wire
